// ---- hw/omc_pkg.sv ----
// Package for the operating mode controller
package omc_pkg;
  // Register byte offsets
  localparam logic [3:0] OMC_OFF_PWR_CTRL = 4'h0;
  localparam logic [3:0] OMC_OFF_CLK_SEL = 4'h4;
  localparam logic [3:0] OMC_OFF_P1_WAKE = 4'h8;
  localparam logic [3:0] OMC_OFF_STATUS = 4'hC;
  // Power control and clock select field positions
  localparam int OMC_BIT_IDLE = 0;
  localparam int OMC_BIT_STOP = 1;
  localparam int OMC_BIT_GPF = 2;
  localparam int OMC_BIT_KEEP_LOW = 4;
  localparam int OMC_BIT_LOW_SEL = 7;
  localparam int OMC_BIT_HIGH_XTAL = 0;
  // Reset values
  localparam logic OMC_RST_LOW_SEL = 1'b1;
  localparam logic [7:0] OMC_RST_P1_WAKE = 8'h00;
  // Timing: wake-up settle counts in oscillator cycles
  localparam int OMC_XTAL_HCYC = 2048;
  localparam int OMC_RC_HCYC = 64;
  localparam int OMC_LOW_CYC = 5;
  // AXI responses
  localparam logic [1:0] OMC_RESP_OKAY = 2'b00;
  localparam logic [1:0] OMC_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    OMC_NORMAL,
    OMC_IDLE,
    OMC_STOP,
    OMC_WARMUP
  } omc_mode_e;
endpackage

// ---- hw/omc_edge_det.sv ----
// Level change detector for one group of wake-capable port pins
`timescale 1ns/100ps
module omc_edge_det
  import omc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arm,
  input wire logic [W-1:0] pins,
  input wire logic [W-1:0] enable,
  output logic change
);
  logic [W-1:0] last_reg;
  logic armed_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      last_reg <= pins;
      armed_reg <= arm;
    end
  end

  // Any enabled pin differing from last sample
  assign change = armed_reg && |((pins ^ last_reg) & enable);
endmodule

// ---- hw/omc_top.sv ----
// Operating mode controller with AXI4-Lite register slave
// Behaviour
// - Four modes: normal, idle, stop, warm-up after stop wake.
// - Reset release places system in normal.
// - Stop bit enters stop, cleared on wake.
// - Idle bit enters idle, cleared on wake.
// - Any wake-up returns to normal mode.
// - CPU halted in idle and stop.
// - Stop halts high oscillators; low clock optional.
// - Stop retains all state and registers.
// - Idle keeps system oscillator and peripherals running.
// - Timer 0 runs in stop only on low clock.
// - ADC runs in stop only on low clock.
// - Stop allows only qualified ADC, timer 0 interrupts.
// - Port change, reset, qualified interrupts wake stop.
// - Port 0 wake always enabled.
// - Enabled interrupts or port changes wake idle.
// - Port 1 wake enabled per bit.
// - Stop wake waits oscillator settle time.
// - Waking interrupt flag set, service runs after.
`timescale 1ns/100ps
module omc_top
  import omc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port0_pins,
  input wire logic [7:0] port1_pins,
  input wire logic global_interrupt_enable,
  input wire logic [11:0] irq_pending,
  input wire logic timer0_irq,
  input wire logic adc_irq,
  input wire logic timer0_on_low_clock,
  input wire logic adc_on_low_clock,
  input wire logic low_clock_tick,
  input wire logic high_clock_tick,
  output logic cpu_run,
  output logic high_osc_run,
  output logic internal_low_rc_osc_run,
  output logic ext_low_xtal_run,
  output logic periph_clk_en,
  output logic timer0_clk_en,
  output logic adc_clk_en,
  output logic stop_irq_en,
  output logic wake_pulse,
  output logic [1:0] op_mode
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic idle_reg;
  logic stop_reg;
  logic gpf_reg;
  logic keep_low_clock_in_stop_reg;
  logic low_clock_source_select_reg;
  logic high_xtal_reg;
  logic [7:0] port1_wake_enable_reg;
  omc_mode_e mode_reg;
  logic [11:0] hcnt_reg;
  logic [2:0] lcnt_reg;
  logic wake;
  logic p0_chg;
  logic p1_chg;
  logic irq_wake;
  logic sleeping;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg[1:0] == 2'b00 &&
          awaddr_reg != OMC_OFF_STATUS) ? OMC_RESP_OKAY : OMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic wr_pwr;
  logic wr_clk;
  logic wr_p1w;
  assign wr_pwr = do_write && awaddr_reg == OMC_OFF_PWR_CTRL && wstrb_reg[0];
  assign wr_clk = do_write && awaddr_reg == OMC_OFF_CLK_SEL && wstrb_reg[0];
  assign wr_p1w = do_write && awaddr_reg == OMC_OFF_P1_WAKE && wstrb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      gpf_reg <= 1'b0;
      keep_low_clock_in_stop_reg <= 1'b0;
    end else if (wake && sleeping) begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else if (wr_pwr && mode_reg == OMC_NORMAL) begin
      stop_reg <= wdata_reg[OMC_BIT_STOP];
      idle_reg <= wdata_reg[OMC_BIT_IDLE];
      gpf_reg <= wdata_reg[OMC_BIT_GPF];
      keep_low_clock_in_stop_reg <= wdata_reg[OMC_BIT_KEEP_LOW];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_clock_source_select_reg <= OMC_RST_LOW_SEL;
      high_xtal_reg <= 1'b0;
    end else if (wr_clk) begin
      low_clock_source_select_reg <= wdata_reg[OMC_BIT_LOW_SEL];
      high_xtal_reg <= wdata_reg[OMC_BIT_HIGH_XTAL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port1_wake_enable_reg <= OMC_RST_P1_WAKE;
    end else if (wr_p1w) begin
      port1_wake_enable_reg <= wdata_reg[7:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= OMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= OMC_RESP_OKAY;
      case (s_axi_araddr)
        OMC_OFF_PWR_CTRL: s_axi_rdata <= {27'h0, keep_low_clock_in_stop_reg,
          1'b0, gpf_reg, stop_reg, idle_reg};
        OMC_OFF_CLK_SEL: s_axi_rdata <= {24'h0, low_clock_source_select_reg,
          6'h0, high_xtal_reg};
        OMC_OFF_P1_WAKE: s_axi_rdata <= {24'h0, port1_wake_enable_reg};
        OMC_OFF_STATUS: s_axi_rdata <= {30'h0, mode_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= OMC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  assign sleeping = mode_reg == OMC_IDLE || mode_reg == OMC_STOP;

  omc_edge_det #(.W(8)) u_p0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .arm(sleeping),
    .pins(port0_pins),
    .enable(8'hFF),
    .change(p0_chg)
  );

  omc_edge_det #(.W(8)) u_p1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .arm(sleeping),
    .pins(port1_pins),
    .enable(port1_wake_enable_reg),
    .change(p1_chg)
  );

  // Interrupt wake differs per mode; flags stay pending for the CPU
  always_comb begin
    irq_wake = 1'b0;
    if (mode_reg == OMC_IDLE) begin
      irq_wake = global_interrupt_enable && |irq_pending;
    end else if (mode_reg == OMC_STOP) begin
      irq_wake = stop_irq_en &&
        ((timer0_irq && timer0_on_low_clock) ||
        (adc_irq && adc_on_low_clock));
    end
  end

  assign wake = sleeping && (p0_chg || p1_chg || irq_wake);

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= OMC_NORMAL;
      hcnt_reg <= 12'h0;
      lcnt_reg <= 3'h0;
    end else begin
      case (mode_reg)
        OMC_NORMAL: begin
          if (wr_pwr && wdata_reg[OMC_BIT_STOP]) begin
            mode_reg <= OMC_STOP;
          end else if (wr_pwr && wdata_reg[OMC_BIT_IDLE]) begin
            mode_reg <= OMC_IDLE;
          end
        end
        OMC_IDLE: begin
          if (wake) begin
            mode_reg <= OMC_NORMAL;
          end
        end
        OMC_STOP: begin
          if (wake) begin
            mode_reg <= OMC_WARMUP;
            hcnt_reg <= high_xtal_reg ? 12'(OMC_XTAL_HCYC)
              : 12'(OMC_RC_HCYC);
            lcnt_reg <= 3'(OMC_LOW_CYC);
          end
        end
        OMC_WARMUP: begin
          if (high_clock_tick && hcnt_reg != 12'h0) begin
            hcnt_reg <= hcnt_reg - 12'h1;
          end
          if (hcnt_reg == 12'h0 && low_clock_tick && lcnt_reg != 3'h0) begin
            lcnt_reg <= lcnt_reg - 3'h1;
          end
          if (hcnt_reg == 12'h0 && lcnt_reg == 3'h0) begin
            mode_reg <= OMC_NORMAL;
          end
        end
        default: mode_reg <= OMC_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock and function gating outputs
  // ----------------------------------------------------------------
  logic stop_like;
  assign stop_like = mode_reg == OMC_STOP;
  assign cpu_run = mode_reg == OMC_NORMAL;
  assign high_osc_run = !stop_like;
  assign internal_low_rc_osc_run = !stop_like ? low_clock_source_select_reg
    : keep_low_clock_in_stop_reg && low_clock_source_select_reg;
  assign ext_low_xtal_run = !stop_like ? !low_clock_source_select_reg
    : keep_low_clock_in_stop_reg && !low_clock_source_select_reg;
  assign periph_clk_en = !stop_like;
  assign stop_irq_en = keep_low_clock_in_stop_reg;
  assign timer0_clk_en = !stop_like ||
    (keep_low_clock_in_stop_reg && timer0_on_low_clock);
  assign adc_clk_en = !stop_like ||
    (keep_low_clock_in_stop_reg && adc_on_low_clock);
  assign wake_pulse = wake;
  assign op_mode = mode_reg;
  // Stop mode writes no state: registers change only on bus writes and on wake
  // (wake clears stop and idle; only power control writes are gated to normal mode above)

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_normal;
    @(posedge aclk) !aresetn |=> mode_reg == OMC_NORMAL;
  endproperty
  a_reset_normal: assert property (p_reset_normal)
    else $error("not normal after reset");

  property p_stop_clear;
    @(posedge aclk) disable iff (!aresetn)
      (mode_reg == OMC_STOP && wake) |=> !stop_reg && !idle_reg;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop bit not cleared");

  property p_idle_wake;
    @(posedge aclk) disable iff (!aresetn)
      (mode_reg == OMC_IDLE && wake) |=> mode_reg == OMC_NORMAL && !idle_reg;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle wake not to normal");

  property p_cpu_halt;
    @(posedge aclk) disable iff (!aresetn)
      sleeping |-> !cpu_run;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt)
    else $error("cpu runs while sleeping");

  property p_stop_osc;
    @(posedge aclk) disable iff (!aresetn)
      stop_like |-> !high_osc_run && (internal_low_rc_osc_run ==
        (keep_low_clock_in_stop_reg && low_clock_source_select_reg));
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("stop oscillator gating wrong");

  property p_t0_stop;
    @(posedge aclk) disable iff (!aresetn)
      (stop_like && !keep_low_clock_in_stop_reg) |-> !timer0_clk_en;
  endproperty
  a_t0_stop: assert property (p_t0_stop)
    else $error("timer0 runs in stop");

  property p_adc_stop;
    @(posedge aclk) disable iff (!aresetn)
      (stop_like && !adc_on_low_clock) |-> !adc_clk_en;
  endproperty
  a_adc_stop: assert property (p_adc_stop)
    else $error("adc runs in stop");

  property p_p0_wake;
    @(posedge aclk) disable iff (!aresetn)
      (mode_reg == OMC_STOP && $stable(mode_reg) &&
      port0_pins != $past(port0_pins)) |-> wake;
  endproperty
  a_p0_wake: assert property (p_p0_wake)
    else $error("port0 change did not wake");

  property p_warmup;
    @(posedge aclk) disable iff (!aresetn)
      (mode_reg == OMC_STOP && wake) |=> mode_reg == OMC_WARMUP [*2];
  endproperty
  a_warmup: assert property (p_warmup)
    else $error("stop wake skipped warm-up");

  property p_both_stop;
    @(posedge aclk) disable iff (!aresetn)
      (mode_reg == OMC_NORMAL && wr_pwr && wdata_reg[OMC_BIT_STOP] &&
      wdata_reg[OMC_BIT_IDLE]) |=> mode_reg == OMC_STOP;
  endproperty
  a_both_stop: assert property (p_both_stop)
    else $error("stop+idle not stop");
endmodule

// ---- sim/omc_osc_model.sv ----
// Oscillator tick model standing at the far side of the controller
`timescale 1ns/100ps
module omc_osc_model #(
  parameter int LOW_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic high_osc_run,
  input wire logic low_run,
  output logic high_clock_tick,
  output logic low_clock_tick
);
  int div_cnt;
  // ------------------------------------------------------------
  // Low oscillator divider
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 0;
    end else begin
      div_cnt <= (div_cnt == LOW_DIV - 1) ? 0 : div_cnt + 1;
    end
  end
  // ------------------------------------------------------------
  // Ticks only while told to run
  // ------------------------------------------------------------
  assign high_clock_tick = high_osc_run;
  assign low_clock_tick = low_run && (div_cnt == 0);
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the operating mode controller
`timescale 1ns/100ps
module testbench;
  import omc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] awaddr = 0;
  logic [3:0] araddr = 0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, mode;
  logic [31:0] rdata;
  logic [7:0] p0 = 0, p1 = 0, p1_en;
  logic gie = 0, t0_irq = 0, adc_irq = 0, t0_low = 0, adc_low = 0;
  logic [11:0] pend = 0;
  logic hi_tick, lo_tick, cpu_run, hi_run, lrc_run, lx_run;
  logic pclk, t0_en, adc_en, sie, wake;
  int n_fail = 0, n_compared = 0, n_wake = 0, seed = 93955;
  logic [33:0] q_r[$];
  logic [1:0] q_b[$];

  always #4 aclk = ~aclk;

  omc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port0_pins(p0),
    .port1_pins(p1), .global_interrupt_enable(gie), .irq_pending(pend),
    .timer0_irq(t0_irq), .adc_irq(adc_irq), .timer0_on_low_clock(t0_low),
    .adc_on_low_clock(adc_low), .low_clock_tick(lo_tick),
    .high_clock_tick(hi_tick), .cpu_run(cpu_run), .high_osc_run(hi_run),
    .internal_low_rc_osc_run(lrc_run), .ext_low_xtal_run(lx_run),
    .periph_clk_en(pclk), .timer0_clk_en(t0_en), .adc_clk_en(adc_en),
    .stop_irq_en(sie), .wake_pulse(wake), .op_mode(mode));

  omc_osc_model osc_u (.aclk(aclk), .aresetn(aresetn), .high_osc_run(hi_run),
    .low_run(lrc_run | lx_run), .high_clock_tick(hi_tick),
    .low_clock_tick(lo_tick));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic timeout;
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  always @(negedge aclk) begin
    if (wake === 1'b1) n_wake++;
    if (bvalid === 1'b1 && bready && q_b.size() > 0)
      chk({32'h0, bresp}, {32'h0, q_b.pop_front()});
    if (rvalid === 1'b1 && rready && q_r.size() > 0)
      chk({rresp, rdata}, q_r.pop_front());
  end

  // ------------------------------------------------------------
  // AXI4-Lite master
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic sa, sw, sb;
    int i;
    q_b.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      sa = awvalid & awready;
      sw = wvalid & wready;
      sb = bvalid;
      @(posedge aclk);
      if (sa) awvalid <= 0;
      if (sw) wvalid <= 0;
      if (sb) begin
        bready <= 0;
        break;
      end
    end
    if (i == 40) timeout();
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic sa, sr;
    int i;
    q_r.push_back({er, ed});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      sa = arvalid & arready;
      sr = rvalid;
      @(posedge aclk);
      if (sa) arvalid <= 0;
      if (sr) begin
        rready <= 0;
        break;
      end
    end
    if (i == 40) timeout();
  endtask

  // Order: cpu, high, low rc, low xtal, periph, timer0, adc, stop irq
  task automatic outs(input logic [7:0] e);
    @(negedge aclk);
    chk({26'h0, cpu_run, hi_run, lrc_run, lx_run, pclk, t0_en, adc_en, sie},
        {26'h0, e});
  endtask

  // ------------------------------------------------------------
  // One sleep and wake cycle
  // ------------------------------------------------------------
  task automatic sleep_case(input logic [7:0] clk, input logic [7:0] pwr,
                            input logic [7:0] eo, input int src,
                            input int lo, input int hi);
    int n;
    logic ok;
    logic [1:0] ms;
    ok = 1;
    ms = pwr[1] ? 2'd2 : 2'd1;
    @(posedge aclk);
    t0_low <= (src == 3);
    adc_low <= (src == 4);
    wr(OMC_OFF_CLK_SEL, clk, OMC_RESP_OKAY);
    wr(OMC_OFF_PWR_CTRL, pwr & 8'h10, OMC_RESP_OKAY);
    wr(OMC_OFF_PWR_CTRL, pwr, OMC_RESP_OKAY);
    rd(OMC_OFF_STATUS, {30'h0, ms}, OMC_RESP_OKAY);
    outs(eo);
    @(posedge aclk);
    p1 <= p1 ^ 8'h80;
    pend <= 12'h001;
    t0_irq <= (src == 4);
    repeat (6) @(posedge aclk);
    rd(OMC_OFF_STATUS, {30'h0, ms}, OMC_RESP_OKAY);
    @(posedge aclk);
    case (src)
      0: p0 <= p0 ^ (8'h01 << ($random(seed) & 7));
      1: p1 <= p1 ^ 8'h01;
      2: gie <= 1;
      3: t0_irq <= 1;
      default: adc_irq <= 1;
    endcase
    for (n = 0; n < 3000; n++) begin
      @(negedge aclk);
      if (mode === OMC_NORMAL) break;
      ok &= (cpu_run === 1'b0);
    end
    if (n == 3000) timeout();
    chk({33'h0, ok}, 34'h1);
    chk({33'h0, (n >= lo && n <= hi)}, 34'h1);
    @(posedge aclk);
    gie <= 0;
    pend <= 0;
    t0_irq <= 0;
    adc_irq <= 0;
    rd(OMC_OFF_PWR_CTRL, {24'h0, pwr & 8'h14}, OMC_RESP_OKAY);
    rd(OMC_OFF_STATUS, 32'h0, OMC_RESP_OKAY);
    rd(OMC_OFF_CLK_SEL, {24'h0, clk}, OMC_RESP_OKAY);
    rd(OMC_OFF_P1_WAKE, {24'h0, p1_en}, OMC_RESP_OKAY);
    outs({2'b11, clk[7], ~clk[7], 3'b111, pwr[4]});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    p1_en = ($random(seed) & 8'h7E) | 8'h01;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(OMC_OFF_STATUS, 32'h0, OMC_RESP_OKAY);
    rd(OMC_OFF_PWR_CTRL, 32'h0, OMC_RESP_OKAY);
    rd(OMC_OFF_CLK_SEL, 32'h80, OMC_RESP_OKAY);
    rd(OMC_OFF_P1_WAKE, 32'h0, OMC_RESP_OKAY);
    rd(4'h6, 32'h0, OMC_RESP_SLVERR);
    wr(OMC_OFF_STATUS, 8'h02, OMC_RESP_SLVERR);
    outs(8'hEE);
    wr(OMC_OFF_P1_WAKE, p1_en, OMC_RESP_OKAY);
    sleep_case(8'h80, 8'h01, 8'h6E, 0, 0, 4);
    sleep_case(8'h80, 8'h05, 8'h6E, 2, 0, 4);
    sleep_case(8'h80, 8'h02, 8'h00, 1, 75, 95);
    sleep_case(8'h81, 8'h13, 8'h25, 3, 2065, 2095);
    sleep_case(8'h00, 8'h12, 8'h13, 4, 75, 95);
    sleep_case(8'h80, 8'h02, 8'h00, 0, 75, 95);
    wr(OMC_OFF_PWR_CTRL, 8'h02, OMC_RESP_OKAY);
    rd(OMC_OFF_STATUS, 32'h2, OMC_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(OMC_OFF_STATUS, 32'h0, OMC_RESP_OKAY);
    rd(OMC_OFF_PWR_CTRL, 32'h0, OMC_RESP_OKAY);
    chk(n_wake, 34'd6);
    complete_run();
  end
endmodule
